/* File: dbl_pkg.sv */
// Package of constants for the drop bus B latched alarm bank
package dbl_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [9:0] DBL_PTR_IDX = 10'h195;
   localparam logic [9:0] DBL_TRC_IDX = 10'h196;
   localparam logic [9:0] DBL_TC_IDX = 10'h197;
   localparam logic [9:0] DBL_EDGE_IDX = 10'h19c;
   localparam logic [9:0] DBL_TCSTAT_IDX = 10'h19d;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int DBL_FIFO_ERR_BIT = 4;
   localparam int DBL_AIS_BIT = 3;
   localparam int DBL_LOP_BIT = 2;
   localparam int DBL_NDF_BIT = 1;
   localparam int DBL_SIZE_BIT = 0;
   localparam int DBL_J2_TIM_BIT = 1;
   localparam int DBL_J2_LOL_BIT = 0;
   localparam int DBL_TC_LOM_BIT = 7;
   localparam int DBL_TC_LOL_BIT = 6;
   localparam int DBL_TC_TIM_BIT = 5;
   localparam int DBL_TC_AIS_BIT = 4;
   localparam int DBL_TC_UQ_BIT = 3;
   localparam int DBL_TC_RDI_BIT = 2;
   localparam int DBL_TC_ODI_BIT = 1;
   // N2 byte: bit 1 is the msb, so bit n sits at index 8-n
   localparam int DBL_N2_AIS_IDX = 4;
   localparam int DBL_N2_UQ_LSB = 0;
   localparam int DBL_N2_UQ_MSB = 5;

   // ------------------------------------------------------------
   // Masks of implemented bits, reset values
   // ------------------------------------------------------------
   localparam logic [7:0] DBL_PTR_MASK = 8'h1f;
   localparam logic [7:0] DBL_TRC_MASK = 8'h03;
   localparam logic [7:0] DBL_TC_MASK = 8'hfe;
   localparam logic [7:0] DBL_LATCH_RST = 8'h00;
   localparam logic [1:0] DBL_EDGE_RST = 2'h0;

   // ------------------------------------------------------------
   // Timing: frames of persistence for the tandem filters
   // ------------------------------------------------------------
   localparam int DBL_PERSIST_FRAMES = 5;

   // ------------------------------------------------------------
   // Transition option
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      DBL_EDGE_RISE = 2'h0,
      DBL_EDGE_FALL = 2'h1,
      DBL_EDGE_BOTH = 2'h3
   } dbl_edge_e;

endpackage : dbl_pkg

/* File: dbl_alarm_bank.sv */
// Drop bus B latched alarm bank with APB register access
// Summary of operation
// - Pointer reg bit 4 latches FIFO error change
// - Pointer reg bit 3 latches AIS change
// - Pointer reg bit 2 latches LOP change
// - Pointer reg bit 1 latches NDF change
// - Pointer reg bit 0 latches size change
// - Trace reg bit 1 latches J2 mismatch
// - Trace reg bit 0 latches J2 lock loss
// - Tandem reg bit 7 latches multiframe loss
// - Tandem reg bit 6 latches trace lock loss
// - Tandem reg bit 5 latches trace mismatch
// - Tandem reg bit 4 latches TC AIS
// - Tandem reg bit 3 latches TC unequipped
// - Tandem reg bit 2 latches TC RDI
// - Tandem reg bit 1 latches TC ODI
// - Latch on rising, falling or both edges
// - Read clears exactly the returned bits
// - TC AIS: five frames set, five clear
// - TC unequipped: five frames on, five off
`timescale 1ns/10ps
module dbl_alarm_bank #(
   parameter int ADDR_W = 12,
   parameter int PERSIST = dbl_pkg::DBL_PERSIST_FRAMES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Unlatched pointer and desynchronizer alarms
   input wire logic desync_fifo_error,
   input wire logic tributary_alarm_signal,
   input wire logic pointer_loss,
   input wire logic new_data_flag,
   input wire logic pointer_size_error,
   // Unlatched J2 trace alarms
   input wire logic path_trace_mismatch,
   input wire logic path_trace_lock_loss,
   // Unlatched tandem alarms from their detectors
   input wire logic tandem_multiframe_loss,
   input wire logic tandem_trace_lock_loss,
   input wire logic tandem_trace_mismatch,
   input wire logic tandem_remote_defect,
   input wire logic tandem_outgoing_defect,
   // N2 byte, one strobe per frame
   input wire logic n2_valid,
   input wire logic [7:0] n2_byte,
   // Filtered tandem states
   output logic tandem_alarm_signal,
   output logic tandem_unequipped
);

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must be 12 to 32");
   end
   if (PERSIST < 1 || PERSIST > 7) begin : g_bad_persist
      $error("PERSIST must be 1 to 7");
   end

   localparam logic [2:0] PERSIST_M1 = 3'(PERSIST - 1);

   // ------------------------------------------------------------
   // Tandem persistence filters
   // ------------------------------------------------------------
   logic [1:0] tc_cand;
   logic [1:0] tc_state_reg;
   logic [2:0] tc_cnt_reg [2];

   assign tc_cand[0] = n2_byte[dbl_pkg::DBL_N2_AIS_IDX];
   assign tc_cand[1] = ~|n2_byte[dbl_pkg::DBL_N2_UQ_MSB:dbl_pkg::DBL_N2_UQ_LSB];

   genvar gf;
   generate
      for (gf = 0; gf < 2; gf++) begin : g_filt
         // Counts frames that disagree with the current state
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               tc_state_reg[gf] <= 1'b0;
               tc_cnt_reg[gf] <= 3'h0;
            end else if (n2_valid) begin
               if (tc_cand[gf] == tc_state_reg[gf]) begin
                  tc_cnt_reg[gf] <= 3'h0;
               end else if (tc_cnt_reg[gf] == PERSIST_M1) begin
                  tc_state_reg[gf] <= tc_cand[gf];
                  tc_cnt_reg[gf] <= 3'h0;
               end else begin
                  tc_cnt_reg[gf] <= tc_cnt_reg[gf] + 3'h1;
               end
            end
         end
      end
   endgenerate

   assign tandem_alarm_signal = tc_state_reg[0];
   assign tandem_unequipped = tc_state_reg[1];

   // ------------------------------------------------------------
   // Alarm vectors, one byte per latch register
   // ------------------------------------------------------------
   logic [23:0] now_vec;
   logic [23:0] prev_reg;
   logic [23:0] rise_vec;
   logic [23:0] fall_vec;
   logic [23:0] set_vec;
   logic [23:0] lat_reg;
   logic [23:0] clr_vec;
   logic [23:0] used_mask;
   logic [1:0] edge_reg;

   assign used_mask = {dbl_pkg::DBL_TC_MASK, dbl_pkg::DBL_TRC_MASK, dbl_pkg::DBL_PTR_MASK};

   always_comb begin
      now_vec = 24'h000000;
      now_vec[dbl_pkg::DBL_FIFO_ERR_BIT] = desync_fifo_error;
      now_vec[dbl_pkg::DBL_AIS_BIT] = tributary_alarm_signal;
      now_vec[dbl_pkg::DBL_LOP_BIT] = pointer_loss;
      now_vec[dbl_pkg::DBL_NDF_BIT] = new_data_flag;
      now_vec[dbl_pkg::DBL_SIZE_BIT] = pointer_size_error;
      now_vec[8 + dbl_pkg::DBL_J2_TIM_BIT] = path_trace_mismatch;
      now_vec[8 + dbl_pkg::DBL_J2_LOL_BIT] = path_trace_lock_loss;
      now_vec[16 + dbl_pkg::DBL_TC_LOM_BIT] = tandem_multiframe_loss;
      now_vec[16 + dbl_pkg::DBL_TC_LOL_BIT] = tandem_trace_lock_loss;
      now_vec[16 + dbl_pkg::DBL_TC_TIM_BIT] = tandem_trace_mismatch;
      now_vec[16 + dbl_pkg::DBL_TC_AIS_BIT] = tc_state_reg[0];
      now_vec[16 + dbl_pkg::DBL_TC_UQ_BIT] = tc_state_reg[1];
      now_vec[16 + dbl_pkg::DBL_TC_RDI_BIT] = tandem_remote_defect;
      now_vec[16 + dbl_pkg::DBL_TC_ODI_BIT] = tandem_outgoing_defect;
   end

   // Previous alarm levels; reset to zero so an alarm high at start reads as a rise
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_reg <= 24'h000000;
      end else begin
         prev_reg <= now_vec;
      end
   end

   assign rise_vec = now_vec & ~prev_reg;
   assign fall_vec = ~now_vec & prev_reg;

   // Transition option selects which edges count
   always_comb begin
      case (dbl_pkg::dbl_edge_e'(edge_reg))
         dbl_pkg::DBL_EDGE_RISE: set_vec = rise_vec;
         dbl_pkg::DBL_EDGE_FALL: set_vec = fall_vec;
         dbl_pkg::DBL_EDGE_BOTH: set_vec = rise_vec | fall_vec;
         default: set_vec = rise_vec | fall_vec;
      endcase
   end

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic setup_ph;
   logic access_ph;
   logic [9:0] idx;
   logic aligned;
   logic hit_ptr;
   logic hit_trc;
   logic hit_tc;
   logic hit_edge;
   logic hit_stat;
   logic mapped;
   logic [31:0] rd_next;
   logic [2:0] sel_reg;

   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign idx = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'h0) && ((paddr >> 12) == '0);
   assign hit_ptr = aligned && idx == dbl_pkg::DBL_PTR_IDX;
   assign hit_trc = aligned && idx == dbl_pkg::DBL_TRC_IDX;
   assign hit_tc = aligned && idx == dbl_pkg::DBL_TC_IDX;
   assign hit_edge = aligned && idx == dbl_pkg::DBL_EDGE_IDX;
   assign hit_stat = aligned && idx == dbl_pkg::DBL_TCSTAT_IDX;
   assign mapped = hit_ptr | hit_trc | hit_tc | hit_edge | hit_stat;
   assign pready = 1'b1;

   always_comb begin
      rd_next = 32'h00000000;
      if (hit_ptr) begin
         rd_next[7:0] = lat_reg[7:0];
      end else if (hit_trc) begin
         rd_next[7:0] = lat_reg[15:8];
      end else if (hit_tc) begin
         rd_next[7:0] = lat_reg[23:16];
      end else if (hit_edge) begin
         rd_next[1:0] = edge_reg;
      end else if (hit_stat) begin
         rd_next[1:0] = tc_state_reg;
      end
   end

   // Snapshot at setup; the access edge clears only what was returned
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         sel_reg <= 3'h0;
      end else if (setup_ph) begin
         prdata <= pwrite ? 32'h00000000 : rd_next;
         pslverr <= ~mapped;
         sel_reg <= pwrite ? 3'h0 : {hit_tc, hit_trc, hit_ptr};
      end
   end

   // Write of the transition option; latch registers ignore writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         edge_reg <= dbl_pkg::DBL_EDGE_RST;
      end else if (access_ph && pwrite && hit_edge && pstrb[0]) begin
         edge_reg <= pwdata[1:0];
      end
   end

   // ------------------------------------------------------------
   // Latches
   // ------------------------------------------------------------
   always_comb begin
      clr_vec = 24'h000000;
      if (access_ph && !pwrite) begin
         if (sel_reg[0]) begin
            clr_vec[7:0] = prdata[7:0];
         end
         if (sel_reg[1]) begin
            clr_vec[15:8] = prdata[7:0];
         end
         if (sel_reg[2]) begin
            clr_vec[23:16] = prdata[7:0];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lat_reg <= {dbl_pkg::DBL_LATCH_RST, dbl_pkg::DBL_LATCH_RST, dbl_pkg::DBL_LATCH_RST};
      end else begin
         lat_reg <= ((lat_reg & ~clr_vec) | set_vec) & used_mask;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence rd_setup_s;
      psel && !penable && !pwrite;
   endsequence

   sequence rd_access_s;
      psel && penable && !pwrite;
   endsequence

   unused_zero_a: assert property ((lat_reg & ~used_mask) == 24'h000000)
      else $error("Unused latch bit set");

   set_wins_a: assert property ((set_vec != 24'h000000) |=> ((lat_reg & $past(set_vec)) == $past(set_vec)))
      else $error("Alarm event not latched");

   no_spurious_a: assert property (((lat_reg & ~$past(lat_reg)) & ~$past(set_vec)) == 24'h000000)
      else $error("Latch bit set without an event");

   rise_mode_a: assert property ((edge_reg == 2'h0 && fall_vec != 24'h000000 && rise_vec == 24'h000000
      && lat_reg == 24'h000000 && clr_vec == 24'h000000) |=> lat_reg == 24'h000000)
      else $error("Falling edge latched in rising mode");

   ptr_read_a: assert property ((rd_setup_s ##0 hit_ptr) |=> prdata == {24'h000000, $past(lat_reg[7:0])})
      else $error("Pointer latch read value wrong");

   read_clear_a: assert property ((rd_setup_s ##1 rd_access_s) |=>
      ((lat_reg & $past(clr_vec) & ~$past(set_vec)) == 24'h000000))
      else $error("Read did not clear returned bits");

   tc_ais_a: assert property ((n2_valid && tc_cand[0] != tc_state_reg[0] && tc_cnt_reg[0] == PERSIST_M1)
      |=> tc_state_reg[0] == $past(tc_cand[0]))
      else $error("Tandem AIS did not change after persistence");

   tc_uq_a: assert property ((n2_valid && tc_cand[1] != tc_state_reg[1] && tc_cnt_reg[1] < PERSIST_M1)
      |=> $stable(tc_state_reg[1]))
      else $error("Tandem unequipped changed too early");

   tc_hold_a: assert property (!n2_valid |=> $stable(tc_state_reg))
      else $error("Tandem state changed without a frame");

   tc_ais_latch_a: assert property ((edge_reg == 2'h3 && $changed(tc_state_reg[0]))
      |=> lat_reg[16 + dbl_pkg::DBL_TC_AIS_BIT])
      else $error("Tandem AIS change not latched");

   unmapped_err_a: assert property ((psel && !penable && !mapped) |=> pslverr && prdata == 32'h00000000)
      else $error("Unmapped access not refused");

   fifo_err_latch_a: assert property ((edge_reg == 2'h0 && $rose(desync_fifo_error))
      |=> lat_reg[dbl_pkg::DBL_FIFO_ERR_BIT])
      else $error("FIFO error rise not latched");

   ais_latch_a: assert property ((edge_reg == 2'h3 && $changed(tributary_alarm_signal))
      |=> lat_reg[dbl_pkg::DBL_AIS_BIT])
      else $error("Tributary AIS change not latched");

   lop_latch_a: assert property ((edge_reg == 2'h1 && $fell(pointer_loss))
      |=> lat_reg[dbl_pkg::DBL_LOP_BIT])
      else $error("Pointer loss fall not latched");

   ndf_latch_a: assert property ((edge_reg == 2'h0 && $rose(new_data_flag))
      |=> lat_reg[dbl_pkg::DBL_NDF_BIT])
      else $error("New data flag rise not latched");

   size_latch_a: assert property ((edge_reg == 2'h1 && $fell(pointer_size_error))
      |=> lat_reg[dbl_pkg::DBL_SIZE_BIT])
      else $error("Pointer size fall not latched");

   path_tim_latch_a: assert property ((edge_reg == 2'h3 && $changed(path_trace_mismatch))
      |=> lat_reg[8 + dbl_pkg::DBL_J2_TIM_BIT])
      else $error("Path trace mismatch change not latched");

   path_lol_latch_a: assert property ((edge_reg == 2'h0 && $rose(path_trace_lock_loss))
      |=> lat_reg[8 + dbl_pkg::DBL_J2_LOL_BIT])
      else $error("Path trace lock loss rise not latched");

   tc_lom_latch_a: assert property ((edge_reg == 2'h1 && $fell(tandem_multiframe_loss))
      |=> lat_reg[16 + dbl_pkg::DBL_TC_LOM_BIT])
      else $error("Tandem multiframe loss fall not latched");

   tc_lol_latch_a: assert property ((edge_reg == 2'h0 && $rose(tandem_trace_lock_loss))
      |=> lat_reg[16 + dbl_pkg::DBL_TC_LOL_BIT])
      else $error("Tandem lock loss rise not latched");

   tc_uq_latch_a: assert property ((edge_reg == 2'h3 && $changed(tc_state_reg[1]))
      |=> lat_reg[16 + dbl_pkg::DBL_TC_UQ_BIT])
      else $error("Tandem unequipped change not latched");

   tc_rdi_latch_a: assert property ((edge_reg == 2'h0 && $rose(tandem_remote_defect))
      |=> lat_reg[16 + dbl_pkg::DBL_TC_RDI_BIT])
      else $error("Tandem RDI rise not latched");

   tc_odi_latch_a: assert property ((edge_reg == 2'h1 && $fell(tandem_outgoing_defect))
      |=> lat_reg[16 + dbl_pkg::DBL_TC_ODI_BIT])
      else $error("Tandem ODI fall not latched");

endmodule : dbl_alarm_bank

/* File: test_dbl_alarm_bank.sv */
// Self-checking testbench for the drop bus B latched alarm bank
`timescale 1ns/10ps
module test_dbl_alarm_bank;
   localparam int P = 2;
   localparam logic [11:0] A_PTR = {dbl_pkg::DBL_PTR_IDX, 2'b00};
   localparam logic [11:0] A_TRC = {dbl_pkg::DBL_TRC_IDX, 2'b00};
   localparam logic [11:0] A_TC = {dbl_pkg::DBL_TC_IDX, 2'b00};
   localparam logic [11:0] A_EDGE = {dbl_pkg::DBL_EDGE_IDX, 2'b00};
   localparam logic [11:0] A_STAT = {dbl_pkg::DBL_TCSTAT_IDX, 2'b00};
   logic clock, rst, psel, penable, pwrite, n2_valid, pready, pslverr, ais_o, uq_o, rnd_on;
   logic [11:0] paddr, al;
   logic [31:0] pwdata, prdata, rd_q, exp_q, lfsr, m_exp;
   logic [3:0] pstrb;
   logic [7:0] n2_byte, m_snap;
   logic [7:0] lat[3];
   logic [7:0] prv[3];
   logic [1:0] m_opt, m_idx;
   logic err_q, xerr_q, m_err, m_ais, m_uq;
   int c_ais, c_uq, err_count, n_checks, n_wait;
   logic [7:0] frames[12] = '{8'h10, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h10, 8'h00, 8'h10, 8'h10};

   dbl_alarm_bank #(.ADDR_W(12), .PERSIST(P)) u_dut (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .desync_fifo_error(al[4]), .tributary_alarm_signal(al[3]), .pointer_loss(al[2]),
      .new_data_flag(al[1]), .pointer_size_error(al[0]), .path_trace_mismatch(al[6]),
      .path_trace_lock_loss(al[5]), .tandem_multiframe_loss(al[11]), .tandem_trace_lock_loss(al[10]),
      .tandem_trace_mismatch(al[9]), .tandem_remote_defect(al[8]), .tandem_outgoing_defect(al[7]),
      .n2_valid(n2_valid), .n2_byte(n2_byte), .tandem_alarm_signal(ais_o), .tandem_unequipped(uq_o));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // ------------------------------------------------------------
   // Reference model of latches, filters and read data
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next

   function automatic logic [7:0] evf(input logic [7:0] c, input logic [7:0] p, input logic [1:0] o);
      if (o == 2'h0) begin
         return c & ~p;
      end else if (o == 2'h1) begin
         return ~c & p;
      end
      return c ^ p;
   endfunction : evf

   always @(posedge clock or posedge rst) begin : model
      logic [7:0] cur[3];
      logic [7:0] clr;
      cur[0] = {3'h0, al[4:0]};
      cur[1] = {6'h0, al[6:5]};
      cur[2] = {al[11:9], m_ais, m_uq, al[8:7], 1'b0};
      if (rst) begin
         lat <= '{8'h0, 8'h0, 8'h0};
         prv <= '{8'h0, 8'h0, 8'h0};
         m_opt <= 2'h0;
         m_idx <= 2'h3;
         m_snap <= 8'h0;
         m_exp <= 32'h0;
         m_err <= 1'b0;
         m_ais <= 1'b0;
         m_uq <= 1'b0;
         c_ais <= 0;
         c_uq <= 0;
      end else begin
         for (int k = 0; k < 3; k++) begin
            clr = (psel && penable && !pwrite && m_idx == k) ? m_snap : 8'h00;
            lat[k] <= (lat[k] & ~clr) | evf(cur[k], prv[k], m_opt);
            prv[k] <= cur[k];
         end
         if (psel && !penable) begin
            m_idx <= 2'h3;
            m_exp <= 32'h0;
            m_err <= 1'b0;
            case (paddr)
               A_PTR: begin
                  m_idx <= 2'h0;
                  m_snap <= lat[0];
                  m_exp <= {24'h0, lat[0]};
               end
               A_TRC: begin
                  m_idx <= 2'h1;
                  m_snap <= lat[1];
                  m_exp <= {24'h0, lat[1]};
               end
               A_TC: begin
                  m_idx <= 2'h2;
                  m_snap <= lat[2];
                  m_exp <= {24'h0, lat[2]};
               end
               A_EDGE: m_exp <= {30'h0, m_opt};
               A_STAT: m_exp <= {30'h0, m_uq, m_ais};
               default: m_err <= 1'b1;
            endcase
            if (pwrite) begin
               m_exp <= 32'h0;
            end
         end
         if (psel && penable && pwrite && paddr == A_EDGE) begin
            m_opt <= pwdata[1:0];
         end
         if (n2_valid) begin
            c_ais <= (n2_byte[4] != m_ais) ? c_ais + 1 : 0;
            c_uq <= ((n2_byte[5:0] == 6'h0) != m_uq) ? c_uq + 1 : 0;
            if (n2_byte[4] != m_ais && c_ais + 1 == P) begin
               m_ais <= n2_byte[4];
               c_ais <= 0;
            end
            if ((n2_byte[5:0] == 6'h0) != m_uq && c_uq + 1 == P) begin
               m_uq <= (n2_byte[5:0] == 6'h0);
               c_uq <= 0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Bus tasks, comparison and closing
   // ------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n_wait = 0;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
         n_wait++;
      end
      rd_q = prdata;
      err_q = pslverr;
      exp_q = m_exp;
      xerr_q = m_err;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd_chk(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
      check(rd_q, exp_q);
      check({31'h0, err_q}, {31'h0, xerr_q});
      check(32'(n_wait), 32'h0);
   endtask : rd_chk

   task chk_all;
      rd_chk(A_PTR);
      rd_chk(A_TRC);
      rd_chk(A_TC);
   endtask : chk_all

   task test_done;
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   // Random alarm toggles and frames, active only in the random phase
   always @(posedge clock) begin
      if (rnd_on) begin
         lfsr = lfsr_next(lfsr);
         al <= al ^ (lfsr[11:0] & lfsr[23:12] & lfsr[19:8]);
         n2_valid <= ~n2_valid & lfsr[31] & lfsr[29];
         n2_byte <= lfsr[27:20];
      end
   end

   initial begin
      repeat (40000) @(posedge clock);
      err_count++;
      test_done;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, n2_valid, rnd_on} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      al = 12'h0;
      n2_byte = 8'h3f;
      lfsr = 32'h8d35;
      err_count = 0;
      n_checks = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      chk_all;
      rd_chk(A_EDGE);
      @(posedge clock);
      al[4] <= 1'b1;
      apb(1'b0, A_PTR, 32'h0);
      check(rd_q, 32'h10);
      apb(1'b0, A_PTR, 32'h0);
      check(rd_q, 32'h0);
      @(posedge clock);
      al[4] <= 1'b0;
      apb(1'b0, A_PTR, 32'h0);
      check(rd_q, 32'h0);
      $display("Test reset and single latch done");
      for (int o = 0; o < 4; o++) begin
         apb(1'b1, A_EDGE, 32'(o));
         rd_chk(A_EDGE);
         for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            al[i] <= 1'b1;
            chk_all;
            @(posedge clock);
            al[i] <= 1'b0;
            chk_all;
         end
      end
      $display("Test edge options done");
      @(posedge clock);
      al[4:0] <= 5'h1f;
      apb(1'b1, A_PTR, 32'h0);
      apb(1'b0, A_PTR, 32'h0);
      check(rd_q, 32'h1f);
      foreach (frames[i]) begin
         apb(1'b0, (i % 2 == 0) ? 12'h655 : 12'hffc, 32'h0);
         check(rd_q, 32'h0);
         check({31'h0, err_q}, 32'h1);
      end
      $display("Test refusals done");
      foreach (frames[i]) begin
         @(posedge clock);
         n2_valid <= 1'b1;
         n2_byte <= frames[i];
         @(posedge clock);
         n2_valid <= 1'b0;
         @(negedge clock);
         check({31'h0, ais_o}, {31'h0, m_ais});
         check({31'h0, uq_o}, {31'h0, m_uq});
         rd_chk(A_STAT);
         rd_chk(A_TC);
      end
      $display("Test tandem filters done");
      @(negedge clock);
      rnd_on = 1'b1;
      repeat (150) chk_all;
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (20) begin
         chk_all;
         rd_chk(A_STAT);
      end
      $display("Test random traffic and reset done");
      test_done;
   end
endmodule : test_dbl_alarm_bank
